// [rtl/switch_timer_pwm_defs.vh]
/*
  Register addresses, field positions, codes and timing constants of the
  switch timer and pulse control block.
  Assumes a 7-bit register address and 8-bit register data.
*/
`ifndef SWITCH_TIMER_PWM_DEFS_VH
`define SWITCH_TIMER_PWM_DEFS_VH

// ********************************************************************
// Register addresses
// ********************************************************************
`define ADDR_FIRST_TIMER 7'h0C
`define ADDR_SECOND_TIMER 7'h0D
`define ADDR_FAULT_POLICY 7'h10
`define ADDR_SOURCE_A 7'h14
`define ADDR_SOURCE_B 7'h15
`define ADDR_PIN_CONFIG 7'h17
`define ADDR_FIRST_DUTY 7'h18
`define ADDR_SECOND_DUTY 7'h19
`define ADDR_PULSE_FREQ 7'h1C

// ********************************************************************
// Writable bit masks, reset value
// ********************************************************************
`define MASK_TIMER 8'h77
`define MASK_POLICY 8'h70
`define MASK_SOURCE 8'h77
`define MASK_FULL 8'hFF
`define MASK_FREQ 8'h05
`define REG_RESET 8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define ON_FIELD 6:4
`define PER_FIELD 2:0
`define LOW_FIELD 2:0
`define HIGH_FIELD 6:4
`define OV_DISABLE_BIT 6
`define UV_DISABLE_BIT 5
`define RECOVERY_BIT 4
`define PIN_ONE_FIELD 2:0
`define PIN_TWO_FIELD 5:3
`define FAIL_DUTY_FIELD 7:6
`define FIRST_RATE_BIT 0
`define SECOND_RATE_BIT 2

// ********************************************************************
// Codes
// ********************************************************************
`define ON_STOP_LOW 3'h0
`define ON_STOP_HIGH 3'h6
`define PER_RESERVED 3'h7
`define SRC_OFF 3'h0
`define SRC_ON 3'h1
`define SRC_TIMER_ONE 3'h2
`define SRC_TIMER_TWO 3'h3
`define SRC_PULSE_ONE 3'h4
`define SRC_PULSE_TWO 3'h5
`define PIN_OFF 3'h4
`define PIN_WAKE 3'h5
`define PIN_LOW_ON 3'h6
`define PIN_HIGH_ON 3'h7

// ********************************************************************
// Timing: base tick is 0.1 ms, timer figures are in ticks
// ********************************************************************
`define CLK_PERIOD_NS 4
`define TICK_NS 100000
`define ON_T1 15'h0001
`define ON_T2 15'h0003
`define ON_T3 15'h000A
`define ON_T4 15'h0064
`define ON_T5 15'h00C8
`define PER_T0 15'h0064
`define PER_T1 15'h00C8
`define PER_T2 15'h01F4
`define PER_T3 15'h03E8
`define PER_T4 15'h07D0
`define PER_T5 15'h2710
`define PER_T6 15'h4E20
`define PULSE_SLOW_NS 5000000
`define PULSE_FAST_NS 2500000
`define PULSE_STEPS 255
`define PULSE_LAST 8'hFE
`define WAKE_FILTER_NS 16000
`define FAIL_PERIOD_TICKS 15'h2710
`define FAIL_ON_20 15'h07D0
`define FAIL_ON_10 15'h03E8
`define FAIL_ON_5 15'h01F4
`define FAIL_ON_2P5 15'h00FA

`endif

// [rtl/cyclic_timer.v]
/*
  One cyclic timer: decodes on-time and period codes and makes a
  repeating high pulse counted in base ticks.
  Assumes a one-cycle tick enable from the parent's divider.
*/
`timescale 1ns/1ns
`include "switch_timer_pwm_defs.vh"

module cyclic_timer (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Control
  input wire tick_in,
  input wire run_in,
  input wire restart_in,
  input wire [2:0] on_code_in,
  input wire [2:0] per_code_in,
  // Output
  output reg wave_out
);

  reg [14:0] on_ticks;
  reg [14:0] per_ticks;
  reg [14:0] cnt_r;
  reg running;

  // ********************************************************************
  // Code decode
  // ********************************************************************
  always @* begin
    on_ticks = 15'h0000;
    per_ticks = `PER_T0;
    running = 1'b1;
    case (on_code_in)
      3'h1: on_ticks = `ON_T1;
      3'h2: on_ticks = `ON_T2;
      3'h3: on_ticks = `ON_T3;
      3'h4: on_ticks = `ON_T4;
      3'h5: on_ticks = `ON_T5;
      default: running = 1'b0;
    endcase
    case (per_code_in)
      3'h0: per_ticks = `PER_T0;
      3'h1: per_ticks = `PER_T1;
      3'h2: per_ticks = `PER_T2;
      3'h3: per_ticks = `PER_T3;
      3'h4: per_ticks = `PER_T4;
      3'h5: per_ticks = `PER_T5;
      3'h6: per_ticks = `PER_T6;
      default: running = 1'b0;
    endcase
  end

  // ********************************************************************
  // Period counter
  // ********************************************************************
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_r <= 15'h0000;
      wave_out <= 1'b0;
    end else if (on_code_in == `ON_STOP_HIGH) begin
      cnt_r <= 15'h0000;
      wave_out <= 1'b1;
    end else if (!running || !run_in || restart_in) begin
      cnt_r <= 15'h0000;
      wave_out <= 1'b0;
    end else begin
      if (tick_in) begin
        if (cnt_r >= per_ticks - 15'h0001) begin
          cnt_r <= 15'h0000;
        end else begin
          cnt_r <= cnt_r + 15'h0001;
        end
      end
      wave_out <= (cnt_r < on_ticks);
    end
  end

endmodule // cyclic_timer

// [rtl/switch_timer_pwm_control.v]
/*
  Control of four high-side switch outputs: source select, two cyclic
  timers, two pulse generators, supply fault policy and two general pins.
  Assumes register writes and reads arrive from the serial frame decoder
  on the same clock; fault, pin and supply inputs are asynchronous.
*/
// How it works
// - Second timer on-time code: stop low, five on-times, stop high.
// - Second timer period code selects 10 ms up to 2 s.
// - An assigned timer starts once a running on-time code is written.
// - Restart clear under cyclic sensing also clears timer settings.
// - Overvoltage shuts all switches unless its disable bit is set.
// - Undervoltage shuts all switches unless its disable bit is set.
// - Recovery bit keeps switch settings so they return after a supply fault.
// - Each switch has a 3-bit source select in low or high nibble.
// - Overcurrent or overtemperature clears that switch's select field.
// - Fail output three pulses at 20, 10, 5 or 2.5 percent duty.
// - Each general pin mode: fail output, off, wake, low or high side.
// - Pulse duty: zero always off, 255 always on, else value/255.
// - Pulse rate bit selects 200 Hz or 400 Hz.
// - Reserved bits ignore writes and read back as zero.
// - First timer uses the same codes in its own register.
`timescale 1ns/1ns
`include "switch_timer_pwm_defs.vh"

module switch_timer_pwm_control #(
  parameter TICK_CYC = `TICK_NS / `CLK_PERIOD_NS,
  parameter STEP_SLOW_CYC = `PULSE_SLOW_NS / `CLK_PERIOD_NS / `PULSE_STEPS,
  parameter STEP_FAST_CYC = `PULSE_FAST_NS / `CLK_PERIOD_NS / `PULSE_STEPS
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Register access
  input wire reg_wr_in,
  input wire [6:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Device state from surrounding logic
  input wire restart_clear_in,
  input wire cyclic_sense_in,
  input wire fail_active_in,
  // Asynchronous fault and pin inputs
  input wire supply_ov_in,
  input wire supply_uv_in,
  input wire [3:0] overcurrent_in,
  input wire [3:0] overtemp_in,
  input wire [1:0] pin_level_in,
  // Switch and pin drive
  output reg [3:0] switch_on_out,
  output reg [1:0] pin_low_on_out,
  output reg [1:0] pin_high_on_out,
  output reg [1:0] pin_wake_out,
  output reg shutdown_out
);

  localparam WAKE_FILT_CYC = `WAKE_FILTER_NS / `CLK_PERIOD_NS;
  localparam NSYNC = 12;

  reg [7:0] first_timer_r;
  reg [7:0] second_timer_config_r;
  reg [7:0] fault_policy_r;
  reg [7:0] source_a_r;
  reg [7:0] source_b_r;
  reg [7:0] pin_config_r;
  reg [7:0] first_duty_r;
  reg [7:0] second_duty_r;
  reg [7:0] freq_r;
  reg [7:0] source_a_nxt;
  reg [7:0] source_b_nxt;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg [NSYNC-1:0] sync3_r;
  reg [NSYNC-1:0] clean_r;
  reg [14:0] tick_cnt_r;
  reg tick_r;
  reg shut_r;
  reg [14:0] fail_cnt_r;
  reg [14:0] fail_on_ticks;
  reg fail_wave_r;
  reg [3:0] field_clr;

  wire supply_ov = clean_r[0];
  wire supply_uv = clean_r[1];
  wire [3:0] oc = clean_r[5:2];
  wire [3:0] ot = clean_r[9:6];
  wire [1:0] pin_level = clean_r[11:10];
  wire [2:0] src [0:3];
  wire [1:0] pulse_wave;
  wire first_wave;
  wire second_wave;
  wire [2:0] pin_mode [0:1];
  wire shut_now;
  wire wr_first_timer = reg_wr_in && (reg_addr_in == `ADDR_FIRST_TIMER);
  wire wr_second_timer = reg_wr_in && (reg_addr_in == `ADDR_SECOND_TIMER);
  wire timer_clear = restart_clear_in && cyclic_sense_in;

  assign src[0] = source_a_r[`LOW_FIELD];
  assign src[1] = source_a_r[`HIGH_FIELD];
  assign src[2] = source_b_r[`LOW_FIELD];
  assign src[3] = source_b_r[`HIGH_FIELD];
  assign pin_mode[0] = pin_config_r[`PIN_ONE_FIELD];
  assign pin_mode[1] = pin_config_r[`PIN_TWO_FIELD];

  // ********************************************************************
  // Input synchronisers: a change counts once stages two and three agree
  // ********************************************************************
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
      sync3_r <= {NSYNC{1'b0}};
      clean_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= {pin_level_in, overtemp_in, overcurrent_in,
                  supply_uv_in, supply_ov_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      clean_r <= (~(sync2_r ^ sync3_r) & sync3_r) |
                 ((sync2_r ^ sync3_r) & clean_r);
    end
  end

  // ********************************************************************
  // Base tick divider
  // ********************************************************************
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      tick_cnt_r <= 15'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC[14:0] - 15'h0001) begin
      tick_cnt_r <= 15'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 15'h0001;
      tick_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Supply fault policy
  // ********************************************************************
  assign shut_now = (supply_ov && !fault_policy_r[`OV_DISABLE_BIT]) ||
                    (supply_uv && !fault_policy_r[`UV_DISABLE_BIT]);

  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      shut_r <= 1'b0;
    end else begin
      shut_r <= shut_now;
    end
  end

  // ********************************************************************
  // Source select fields with hardware clears
  // ********************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : clr_gen
      always @* begin
        field_clr[g] = oc[g] || ot[g] || restart_clear_in ||
                       (shut_now && !shut_r &&
                        !fault_policy_r[`RECOVERY_BIT]);
      end
    end
  endgenerate

  always @* begin
    source_a_nxt = source_a_r;
    source_b_nxt = source_b_r;
    if (reg_wr_in && reg_addr_in == `ADDR_SOURCE_A) begin
      source_a_nxt = reg_wdata_in & `MASK_SOURCE;
    end
    if (reg_wr_in && reg_addr_in == `ADDR_SOURCE_B) begin
      source_b_nxt = reg_wdata_in & `MASK_SOURCE;
    end
    if (field_clr[0]) begin
      source_a_nxt[`LOW_FIELD] = `SRC_OFF;
    end
    if (field_clr[1]) begin
      source_a_nxt[`HIGH_FIELD] = `SRC_OFF;
    end
    if (field_clr[2]) begin
      source_b_nxt[`LOW_FIELD] = `SRC_OFF;
    end
    if (field_clr[3]) begin
      source_b_nxt[`HIGH_FIELD] = `SRC_OFF;
    end
  end

  // ********************************************************************
  // Register file
  // ********************************************************************
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      first_timer_r <= `REG_RESET;
      second_timer_config_r <= `REG_RESET;
      fault_policy_r <= `REG_RESET;
      source_a_r <= `REG_RESET;
      source_b_r <= `REG_RESET;
      pin_config_r <= `REG_RESET;
      first_duty_r <= `REG_RESET;
      second_duty_r <= `REG_RESET;
      freq_r <= `REG_RESET;
    end else begin
      source_a_r <= source_a_nxt;
      source_b_r <= source_b_nxt;
      if (timer_clear) begin
        first_timer_r <= `REG_RESET;
        second_timer_config_r <= `REG_RESET;
      end else begin
        if (wr_first_timer) begin
          first_timer_r <= reg_wdata_in & `MASK_TIMER;
        end
        if (wr_second_timer) begin
          second_timer_config_r <= reg_wdata_in & `MASK_TIMER;
        end
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `ADDR_FAULT_POLICY: fault_policy_r <= reg_wdata_in & `MASK_POLICY;
          `ADDR_PIN_CONFIG: pin_config_r <= reg_wdata_in & `MASK_FULL;
          `ADDR_FIRST_DUTY: first_duty_r <= reg_wdata_in & `MASK_FULL;
          `ADDR_SECOND_DUTY: second_duty_r <= reg_wdata_in & `MASK_FULL;
          `ADDR_PULSE_FREQ: freq_r <= reg_wdata_in & `MASK_FREQ;
          default: ;
        endcase
      end
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `ADDR_FIRST_TIMER: reg_rdata_out <= first_timer_r;
        `ADDR_SECOND_TIMER: reg_rdata_out <= second_timer_config_r;
        `ADDR_FAULT_POLICY: reg_rdata_out <= fault_policy_r;
        `ADDR_SOURCE_A: reg_rdata_out <= source_a_r;
        `ADDR_SOURCE_B: reg_rdata_out <= source_b_r;
        `ADDR_PIN_CONFIG: reg_rdata_out <= pin_config_r;
        `ADDR_FIRST_DUTY: reg_rdata_out <= first_duty_r;
        `ADDR_SECOND_DUTY: reg_rdata_out <= second_duty_r;
        `ADDR_PULSE_FREQ: reg_rdata_out <= freq_r;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ********************************************************************
  // Cyclic timers
  // ********************************************************************
  wire first_assigned = (src[0] == `SRC_TIMER_ONE) ||
                        (src[1] == `SRC_TIMER_ONE) ||
                        (src[2] == `SRC_TIMER_ONE) ||
                        (src[3] == `SRC_TIMER_ONE);
  wire second_assigned = (src[0] == `SRC_TIMER_TWO) ||
                         (src[1] == `SRC_TIMER_TWO) ||
                         (src[2] == `SRC_TIMER_TWO) ||
                         (src[3] == `SRC_TIMER_TWO);

  cyclic_timer first_timer_u (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_r),
    .run_in(first_assigned),
    .restart_in(wr_first_timer),
    .on_code_in(first_timer_r[`ON_FIELD]),
    .per_code_in(first_timer_r[`PER_FIELD]),
    .wave_out(first_wave)
  );

  cyclic_timer second_timer_u (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_r),
    .run_in(second_assigned),
    .restart_in(wr_second_timer),
    .on_code_in(second_timer_config_r[`ON_FIELD]),
    .per_code_in(second_timer_config_r[`PER_FIELD]),
    .wave_out(second_wave)
  );

  // ********************************************************************
  // Pulse generators
  // ********************************************************************
  generate
    for (g = 0; g < 2; g = g + 1) begin : pulse_gen
      reg [12:0] pre_r;
      reg [7:0] step_r;
      reg wave_r;
      wire fast = (g == 0) ? freq_r[`FIRST_RATE_BIT] :
                             freq_r[`SECOND_RATE_BIT];
      wire [12:0] step_cyc = fast ? STEP_FAST_CYC[12:0] :
                                    STEP_SLOW_CYC[12:0];
      wire [7:0] duty = (g == 0) ? first_duty_r : second_duty_r;
      always @(posedge mclk_in) begin
        if (!rst_b_in) begin
          pre_r <= 13'h0000;
          step_r <= 8'h00;
          wave_r <= 1'b0;
        end else begin
          if (pre_r >= step_cyc - 13'h0001) begin
            pre_r <= 13'h0000;
            if (step_r >= `PULSE_LAST) begin
              step_r <= 8'h00;
            end else begin
              step_r <= step_r + 8'h01;
            end
          end else begin
            pre_r <= pre_r + 13'h0001;
          end
          wave_r <= (step_r < duty);
        end
      end
      assign pulse_wave[g] = wave_r;
    end
  endgenerate

  // ********************************************************************
  // Fail output three duty
  // ********************************************************************
  always @* begin
    case (pin_config_r[`FAIL_DUTY_FIELD])
      2'h0: fail_on_ticks = `FAIL_ON_20;
      2'h1: fail_on_ticks = `FAIL_ON_10;
      2'h2: fail_on_ticks = `FAIL_ON_5;
      default: fail_on_ticks = `FAIL_ON_2P5;
    endcase
  end

  always @(posedge mclk_in) begin
    if (!rst_b_in || !fail_active_in) begin
      fail_cnt_r <= 15'h0000;
      fail_wave_r <= 1'b0;
    end else begin
      if (tick_r) begin
        if (fail_cnt_r >= `FAIL_PERIOD_TICKS - 15'h0001) begin
          fail_cnt_r <= 15'h0000;
        end else begin
          fail_cnt_r <= fail_cnt_r + 15'h0001;
        end
      end
      fail_wave_r <= (fail_cnt_r < fail_on_ticks);
    end
  end

  // ********************************************************************
  // Switch outputs
  // ********************************************************************
  generate
    for (g = 0; g < 4; g = g + 1) begin : sw_gen
      reg drive;
      always @* begin
        case (src[g])
          `SRC_ON: drive = 1'b1;
          `SRC_TIMER_ONE: drive = first_wave;
          `SRC_TIMER_TWO: drive = second_wave;
          `SRC_PULSE_ONE: drive = pulse_wave[0];
          `SRC_PULSE_TWO: drive = pulse_wave[1];
          default: drive = 1'b0;
        endcase
      end
      always @(posedge mclk_in) begin
        if (!rst_b_in) begin
          switch_on_out[g] <= 1'b0;
        end else begin
          switch_on_out[g] <= drive && !shut_now;
        end
      end
    end
  endgenerate

  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      shutdown_out <= 1'b0;
    end else begin
      shutdown_out <= shut_now;
    end
  end

  // ********************************************************************
  // General pins
  // ********************************************************************
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_gen
      reg [11:0] filt_cnt_r;
      wire is_fail = !pin_mode[g][2];
      wire fail_drive = (g == 0) ? fail_active_in :
                                   (fail_active_in && fail_wave_r);
      always @(posedge mclk_in) begin
        if (!rst_b_in) begin
          filt_cnt_r <= 12'h000;
          pin_low_on_out[g] <= 1'b0;
          pin_high_on_out[g] <= 1'b0;
          pin_wake_out[g] <= 1'b0;
        end else begin
          pin_low_on_out[g] <= (pin_mode[g] == `PIN_LOW_ON) ||
                               (is_fail && fail_drive);
          pin_high_on_out[g] <= (pin_mode[g] == `PIN_HIGH_ON);
          if (pin_mode[g] != `PIN_WAKE) begin
            filt_cnt_r <= 12'h000;
            pin_wake_out[g] <= 1'b0;
          end else if (pin_level[g] == pin_wake_out[g]) begin
            filt_cnt_r <= 12'h000;
          end else if (filt_cnt_r >= WAKE_FILT_CYC[11:0] - 12'h001) begin
            filt_cnt_r <= 12'h000;
            pin_wake_out[g] <= pin_level[g];
          end else begin
            filt_cnt_r <= filt_cnt_r + 12'h001;
          end
        end
      end
    end
  endgenerate

endmodule // switch_timer_pwm_control

// [test/switch_load_model.sv]
/* Loads on the four switch outputs.
   Assumes the bench picks which load is shorted or overheated. */
`timescale 1ns/1ns
module switch_load_model (
  // Switch drive and fault picks
  input wire [3:0] switch_on_out,
  input wire [3:0] short_sel,
  input wire [3:0] hot_sel,
  // Fault reports
  output wire [3:0] overcurrent_in,
  output wire [3:0] overtemp_in
);
  // A load only shows a fault while its switch is driving it
  assign overcurrent_in = switch_on_out & short_sel;
  assign overtemp_in = switch_on_out & hot_sel;
endmodule // switch_load_model

// [test/switch_ctrl_props.sv]
/* Assertions on the switch control ports.
   Assumes it is bound to the top module. */
`timescale 1ns/1ns
module switch_ctrl_props #(
  parameter TICK_CYC = 1,
  parameter STEP_SLOW_CYC = 1,
  parameter STEP_FAST_CYC = 1
) (
  // Clock, reset, register port
  input wire mclk_in, rst_b_in, reg_wr_in,
  input wire [6:0] reg_addr_in,
  input wire [7:0] reg_wdata_in, reg_rdata_out,
  // State and faults
  input wire restart_clear_in, cyclic_sense_in, fail_active_in,
  input wire supply_ov_in, supply_uv_in, shutdown_out,
  input wire [3:0] overcurrent_in, overtemp_in, switch_on_out,
  // Pins
  input wire [1:0] pin_level_in, pin_low_on_out, pin_high_on_out,
  input wire [1:0] pin_wake_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // ****
  // Sequences and properties
  // ****
  sequence wr_one_on;
    reg_wr_in && reg_addr_in == 7'h14 && reg_wdata_in[2:0] == 3'h1 &&
    !restart_clear_in && !shutdown_out ##1 !reg_wr_in;
  endsequence
  sequence clr_two;
    (restart_clear_in && cyclic_sense_in) [*2];
  endsequence
  unmapped_zero_a:
  assert property (!(reg_addr_in inside {7'h0C, 7'h0D, 7'h10, 7'h14,
    7'h15, 7'h17, 7'h18, 7'h19, 7'h1C}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  select_rsvd_a:
  assert property (reg_addr_in inside {7'h0C, 7'h0D, 7'h14, 7'h15}
    |=> (reg_rdata_out & 8'h88) == 8'h00)
    else $error("reserved bit read as one");
  shut_off_a:
  assert property (shutdown_out && $past(shutdown_out)
    |-> switch_on_out == 4'h0) else $error("switch on while shut");
  write_on_a:
  assert property (wr_one_on |=> switch_on_out[0] || shutdown_out)
    else $error("switch one not on after write");
  restart_off_a:
  assert property (restart_clear_in [*3] |=> switch_on_out == 4'h0)
    else $error("switch on during restart clear");
  timer_clear_a:
  assert property (clr_two ##0 reg_addr_in == 7'h0D
    |=> reg_rdata_out == 8'h00) else $error("timer not cleared");
  pin_excl_a:
  assert property ((pin_high_on_out & pin_low_on_out) == 2'h0)
    else $error("pin driven both ways");
  oc_clear_a:
  assert property (overcurrent_in[0] [*4] |-> ##5 !switch_on_out[0])
    else $error("switch one kept on in overcurrent");
endmodule // switch_ctrl_props
bind switch_timer_pwm_control switch_ctrl_props #(.TICK_CYC(TICK_CYC),
  .STEP_SLOW_CYC(STEP_SLOW_CYC), .STEP_FAST_CYC(STEP_FAST_CYC)) i_props (.*);

// [test/test_switch_timer_pwm_control.sv]
/* Bench of the switch timer and pulse block: register tasks and tests.
   Assumes the load model on the switch outputs. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %0h got %0h", n, e, g); \
  end end
module test_switch_timer_pwm_control;
  localparam int TK = 10;
  localparam int SS = 4;
  localparam int SF = 2;
  logic mclk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0;
  logic restart_clear_in = 1'b0, cyclic_sense_in = 1'b0;
  logic fail_active_in = 1'b0, supply_ov_in = 1'b0, supply_uv_in = 1'b0;
  logic [6:0] reg_addr_in = 7'h00;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, srcmap = 8'h16;
  logic [3:0] short_sel = 4'h0, hot_sel = 4'h0;
  logic [3:0] overcurrent_in, overtemp_in, switch_on_out;
  logic [1:0] pin_level_in = 2'h0, pin_low_on_out, pin_high_on_out;
  logic [1:0] pin_wake_out;
  logic shutdown_out;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [14:0] regs [9] = '{{7'h0C, 8'h77}, {7'h0D, 8'h77},
    {7'h10, 8'h70}, {7'h14, 8'h77}, {7'h15, 8'h77}, {7'h17, 8'hFF},
    {7'h18, 8'hFF}, {7'h19, 8'hFF}, {7'h1C, 8'h05}};
  logic [7:0] tv [7] = '{8'h10, 8'h20, 8'h30, 8'h42, 8'h52, 8'h11, 8'h13};
  int th [7] = '{TK, 3 * TK, 10 * TK, 100 * TK, 200 * TK, TK, TK};
  int tw [7] = '{100 * TK, 100 * TK, 100 * TK, 500 * TK, 500 * TK, 200 * TK,
    1000 * TK};
  switch_timer_pwm_control #(.TICK_CYC(TK), .STEP_SLOW_CYC(SS),
    .STEP_FAST_CYC(SF)) i_dut (.*);
  switch_load_model i_load (.*);
  initial forever #2 mclk_in = ~mclk_in;
  // ****
  // Register tasks and helpers
  // ****
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, string n);
    @(posedge mclk_in);
    reg_addr_in <= a;
    @(posedge mclk_in);
    #1 `CHK(n, e, reg_rdata_out)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic hi(input int w, output int h);
    h = 0;
    repeat (w) begin
      @(posedge mclk_in);
      #1 h += switch_on_out[0];
    end
  endtask
  task automatic sup(input logic [7:0] p, input logic o, u, s, b);
    wr(7'h10, p);
    wr(7'h14, 8'h01);
    supply_ov_in <= o;
    supply_uv_in <= u;
    idle(12);
    `CHK("shutdown", s, shutdown_out)
    `CHK("switches", s ? 4'h0 : 4'h1, switch_on_out)
    @(posedge mclk_in);
    supply_ov_in <= 1'b0;
    supply_uv_in <= 1'b0;
    idle(12);
    `CHK("recovery", b, switch_on_out[0])
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    int h;
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    foreach (regs[i]) rd(regs[i][14:8], 8'h00, "reset");
    foreach (regs[i]) wr(regs[i][14:8], 8'hFF);
    wr(7'h1E, 8'hFF);
    foreach (regs[i]) rd(regs[i][14:8], regs[i][7:0], "mask");
    rd(7'h1E, 8'h00, "unmapped");
    foreach (regs[i]) wr(regs[i][14:8], 8'h00);
    $display("test registers done");
    wr(7'h18, 8'hFF);
    wr(7'h0C, 8'h60);
    for (int c = 0; c < 8; c++) begin
      wr(7'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
      wr(7'h15, {1'b0, c[2:0], 1'b0, c[2:0]});
      idle(3);
      `CHK("source", {4{srcmap[c]}}, switch_on_out)
    end
    $display("test sources done");
    wr(7'h14, 8'h03);
    foreach (tv[i]) begin
      wr(7'h0D, tv[i]);
      idle(20);
      hi(tw[i], h);
      `CHK("on time", th[i], h)
    end
    wr(7'h14, 8'h02);
    wr(7'h0C, 8'h10);
    idle(20);
    hi(tw[0], h);
    `CHK("first timer", th[0], h)
    $display("test timers done");
    for (int k = 0; k < 4; k++) begin
      wr(7'h18 + 7'(k[1]), 8'h80);
      wr(7'h14, 8'h04 + 8'(k[1]));
      wr(7'h1C, 8'(k[0]) << (2 * k[1]));
      idle(20);
      hi(255 * (k[0] ? SF : SS), h);
      `CHK("duty", 128 * (k[0] ? SF : SS), h)
    end
    $display("test pulses done");
    sup(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    sup(8'h10, 1'b0, 1'b1, 1'b1, 1'b1);
    sup(8'h60, 1'b1, 1'b1, 1'b0, 1'b1);
    $display("test supply done");
    wr(7'h15, 8'h01);
    wr(7'h14, 8'h01);
    short_sel <= 4'h1;
    hot_sel <= 4'h4;
    idle(20);
    rd(7'h14, 8'h00, "overcurrent");
    rd(7'h15, 8'h00, "overtemp");
    @(posedge mclk_in);
    short_sel <= 4'h0;
    hot_sel <= 4'h0;
    $display("test faults done");
    wr(7'h0D, 8'h11);
    wr(7'h14, 8'h31);
    restart_clear_in <= 1'b1;
    idle(3);
    rd(7'h0D, 8'h11, "timer kept");
    @(posedge mclk_in);
    cyclic_sense_in <= 1'b1;
    idle(3);
    rd(7'h0D, 8'h00, "timer cleared");
    `CHK("restart", 4'h0, switch_on_out)
    @(posedge mclk_in);
    restart_clear_in <= 1'b0;
    cyclic_sense_in <= 1'b0;
    $display("test restart done");
    wr(7'h17, 8'h3E);
    idle(3);
    `CHK("pin drive", 4'h9, {pin_high_on_out, pin_low_on_out})
    wr(7'h17, 8'h2D);
    pin_level_in <= 2'h3;
    idle(3900);
    `CHK("wake early", 2'h0, pin_wake_out)
    idle(120);
    `CHK("wake", 2'h3, pin_wake_out)
    wr(7'h17, 8'h00);
    fail_active_in <= 1'b1;
    idle(3);
    `CHK("fail pin", 1'b1, pin_low_on_out[0])
    // On-time of 2.5 and 5 percent in a 10000-tick period
    for (int d = 3; d > 1; d--) begin
      fail_active_in <= 1'b0;
      wr(7'h17, 8'(d) << 6);
      fail_active_in <= 1'b1;
      idle(TK * (250 << (3 - d)) - 100);
      `CHK("fail on", 1'b1, pin_low_on_out[1])
      idle(120);
      `CHK("fail off", 1'b0, pin_low_on_out[1])
    end
    $display("test pins done");
    tally_and_finish();
  end
endmodule // test_switch_timer_pwm_control
